// File: hdl/cbid_regs.sv
/*
  Identification and block-read-length registers at indices 4 to 7, with the
  block-read sequencer that uses the length.
  Assumes a serial management engine on the same clock presents decoded byte
  accesses and block-read byte requests; the bus protocol lives there.
*/
// Summary of operation
// R1: Index 4 reserved, always reads all ones.
// R2: Index 5 read-only revision and maker codes.
// R3: Index 6 read-only category and part codes.
// R4: Index 7 five-bit block length, reset eight.
// R5: Block read sends count, then consecutive bytes.
// R6: Writes to read-only or reserved bits ignored.
`timescale 1ns/1ns
`include "cbid_defines.svh"

module cbid_regs #(
  // Identification values; these defaults are arbitrary.
  parameter logic [3:0] REVISION_CODE = 4'h3,
  parameter logic [3:0] MAKER_CODE    = 4'h5,
  parameter logic [1:0] CATEGORY_CODE = 2'h2,
  parameter logic [5:0] PART_CODE     = 6'h15
) (
  // Clock, reset, enable.
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 ce,
  // Single register access.
  input  wire logic                 accValid,
  input  wire logic                 accWrite,
  input  wire logic [7:0]           accIndex,
  input  wire cbid_pkg::cbid_byte_t accWrData,
  output cbid_pkg::cbid_byte_t      accRdData,
  output logic                      accRdValid,
  // Block read.
  input  wire logic                 blkStart,
  input  wire logic [7:0]           blkIndex,
  input  wire logic                 blkNext,
  input  wire logic                 blkAbort,
  output cbid_pkg::cbid_byte_t      blkData,
  output logic                      blkDataValid,
  output logic                      blkLast,
  output logic                      blkBusy,
  // Current block length for the rest of the device.
  output cbid_pkg::cbid_len_t       readLength
);

  cbid_pkg::cbid_len_t  readLength_r;
  logic [7:0]           seqIndex;
  cbid_pkg::cbid_byte_t seqRdData;

  assign readLength = readLength_r;

  // One decode serves both single reads and block reads so they never disagree.
  function automatic cbid_pkg::cbid_byte_t readReg(input logic [7:0] idx, input cbid_pkg::cbid_len_t len);
    cbid_pkg::cbid_byte_t val;
    val = `CBID_UNMAPPED_VALUE;
    case (idx)
      `CBID_IDX_RESERVED: begin
        val = `CBID_RESERVED_VALUE; // [R1]
      end
      `CBID_IDX_REV_MAKER: begin
        val[`CBID_REV_MSB:`CBID_REV_LSB]     = REVISION_CODE; // [R2]
        val[`CBID_MAKER_MSB:`CBID_MAKER_LSB] = MAKER_CODE; // [R2]
      end
      `CBID_IDX_CAT_PART: begin
        val[`CBID_CAT_MSB:`CBID_CAT_LSB]   = CATEGORY_CODE; // [R3]
        val[`CBID_PART_MSB:`CBID_PART_LSB] = PART_CODE; // [R3]
      end
      `CBID_IDX_READ_LENGTH: begin
        // Reserved upper bits read as zero.
        val[`CBID_LEN_MSB:`CBID_LEN_LSB] = len; // [R4]
      end
      default: begin
        val = `CBID_UNMAPPED_VALUE;
      end
    endcase
    return val;
  endfunction

  assign seqRdData = readReg(seqIndex, readLength_r);

  // Length register; every other index has no write path at all. [R6]
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      readLength_r <= `CBID_LEN_RESET; // [R4]
    end else if (ce) begin
      if (accValid && accWrite && accIndex == `CBID_IDX_READ_LENGTH) begin
        // Only the low five bits are kept; the reserved bits are dropped. [R4] [R6]
        readLength_r <= accWrData[`CBID_LEN_MSB:`CBID_LEN_LSB];
      end
    end
  end

  // Single reads answer one cycle after the request.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      accRdData  <= 8'h00;
      accRdValid <= 1'b0;
    end else if (ce) begin
      accRdValid <= accValid && !accWrite;
      if (accValid && !accWrite) begin
        accRdData <= readReg(accIndex, readLength_r); // [R1] [R2] [R3]
      end
    end
  end

  cbid_block_seq u_seq (
    .clk          (clk),
    .reset_n      (reset_n),
    .ce           (ce),
    .blkStart     (blkStart),
    .blkIndex     (blkIndex),
    .blkNext      (blkNext),
    .blkAbort     (blkAbort),
    .readLength   (readLength_r),
    .seqIndex     (seqIndex),
    .seqRdData    (seqRdData),
    .blkData      (blkData),
    .blkDataValid (blkDataValid),
    .blkLast      (blkLast),
    .blkBusy      (blkBusy)
  );

  property p_reserved_ones;
    @(posedge clk) disable iff (!reset_n)
    (ce && accValid && !accWrite && accIndex == `CBID_IDX_RESERVED) |=>
      (accRdValid && accRdData == `CBID_RESERVED_VALUE);
  endproperty
  a_reserved_ones: assert property (p_reserved_ones) else $error("Reserved index did not read all ones."); // [R1]

  property p_rev_maker;
    @(posedge clk) disable iff (!reset_n)
    (ce && accValid && !accWrite && accIndex == `CBID_IDX_REV_MAKER) |=> (accRdData == {REVISION_CODE, MAKER_CODE});
  endproperty
  a_rev_maker: assert property (p_rev_maker) else $error("Revision and maker byte is wrong."); // [R2]

  property p_cat_part;
    @(posedge clk) disable iff (!reset_n)
    (ce && accValid && !accWrite && accIndex == `CBID_IDX_CAT_PART) |=> (accRdData == {CATEGORY_CODE, PART_CODE});
  endproperty
  a_cat_part: assert property (p_cat_part) else $error("Category and part byte is wrong."); // [R3]

  property p_len_write;
    @(posedge clk) disable iff (!reset_n)
    (ce && accValid && accWrite && accIndex == `CBID_IDX_READ_LENGTH) |=>
      (readLength_r == $past(accWrData[`CBID_LEN_MSB:`CBID_LEN_LSB]));
  endproperty
  a_len_write: assert property (p_len_write) else $error("Length write not taken."); // [R4]

  property p_len_reset;
    @(posedge clk) (!reset_n) |=> (readLength_r == `CBID_LEN_RESET);
  endproperty
  a_len_reset: assert property (p_len_reset) else $error("Length did not reset to eight."); // [R4]

  property p_len_readback;
    @(posedge clk) disable iff (!reset_n)
    (ce && accValid && !accWrite && accIndex == `CBID_IDX_READ_LENGTH) |=> (accRdData == {3'h0, $past(readLength_r)});
  endproperty
  a_len_readback: assert property (p_len_readback) else $error("Length readback is wrong."); // [R4]

  property p_ro_ignored;
    @(posedge clk) disable iff (!reset_n)
    (accValid && accWrite && accIndex != `CBID_IDX_READ_LENGTH) |=> $stable(readLength_r);
  endproperty
  a_ro_ignored: assert property (p_ro_ignored) else $error("Write to read-only index changed state."); // [R6]

  // Read-valid and length-hold checks, then the block-read bytes, checked here where the identification values are known.
  property p_rdvalid_quiet;
    @(posedge clk) disable iff (!reset_n)
    (ce && !(accValid && !accWrite)) |=> !accRdValid;
  endproperty
  a_rdvalid_quiet: assert property (p_rdvalid_quiet) else $error("Read answer without a read request."); // [R1] [R2] [R3]

  property p_len_hold;
    @(posedge clk) disable iff (!reset_n)
    !(ce && accValid && accWrite && accIndex == `CBID_IDX_READ_LENGTH) |=> $stable(readLength_r);
  endproperty
  a_len_hold: assert property (p_len_hold) else $error("Length changed without a length write."); // [R6]

  property p_blk_reserved;
    @(posedge clk) disable iff (!reset_n)
    (ce && blkBusy && !blkAbort && blkNext && seqIndex == `CBID_IDX_RESERVED) |=>
      (blkData == `CBID_RESERVED_VALUE);
  endproperty
  a_blk_reserved: assert property (p_blk_reserved) else $error("Block byte of reserved index is wrong."); // [R1] [R5]

  property p_blk_rev_maker;
    @(posedge clk) disable iff (!reset_n)
    (ce && blkBusy && !blkAbort && blkNext && seqIndex == `CBID_IDX_REV_MAKER) |=>
      (blkData == {REVISION_CODE, MAKER_CODE});
  endproperty
  a_blk_rev_maker: assert property (p_blk_rev_maker) else $error("Block byte of revision index is wrong."); // [R2] [R5]

  property p_blk_cat_part;
    @(posedge clk) disable iff (!reset_n)
    (ce && blkBusy && !blkAbort && blkNext && seqIndex == `CBID_IDX_CAT_PART) |=>
      (blkData == {CATEGORY_CODE, PART_CODE});
  endproperty
  a_blk_cat_part: assert property (p_blk_cat_part) else $error("Block byte of category index is wrong."); // [R3] [R5]

  property p_blk_len_byte;
    @(posedge clk) disable iff (!reset_n)
    (ce && blkBusy && !blkAbort && blkNext && seqIndex == `CBID_IDX_READ_LENGTH) |=>
      (blkData == {3'h0, $past(readLength_r)});
  endproperty
  a_blk_len_byte: assert property (p_blk_len_byte) else $error("Block byte of length index is wrong."); // [R4] [R5]

  property p_blk_len_zero;
    @(posedge clk) disable iff (!reset_n)
    (ce && !blkBusy && blkStart && readLength_r == 5'h00) |=> (blkDataValid && blkLast && !blkBusy);
  endproperty
  a_blk_len_zero: assert property (p_blk_len_zero) else $error("Zero length block did not end at once."); // [R4] [R5]

  property p_blk_idle_quiet;
    @(posedge clk) disable iff (!reset_n)
    (ce && !blkBusy && !blkStart) |=> !blkDataValid;
  endproperty
  a_blk_idle_quiet: assert property (p_blk_idle_quiet) else $error("Block byte while idle."); // [R5]

  property p_blk_abort;
    @(posedge clk) disable iff (!reset_n)
    (ce && blkBusy && blkAbort) |=> (!blkBusy && !blkDataValid);
  endproperty
  a_blk_abort: assert property (p_blk_abort) else $error("Block read went on after abort."); // [R5]

endmodule // cbid_regs

// File: hdl/cbid_defines.svh
/*
  Offsets, field positions, reset values and fixed answers of the identification
  and block-read-length registers.
  Assumes it is included by bare name wherever these values are needed.
*/
`ifndef CBID_DEFINES_SVH
`define CBID_DEFINES_SVH

`define CBID_IDX_RESERVED     8'h04
`define CBID_IDX_REV_MAKER    8'h05
`define CBID_IDX_CAT_PART     8'h06
`define CBID_IDX_READ_LENGTH  8'h07

`define CBID_RESERVED_VALUE   8'hFF
`define CBID_UNMAPPED_VALUE   8'h00

`define CBID_REV_MSB          7
`define CBID_REV_LSB          4
`define CBID_MAKER_MSB        3
`define CBID_MAKER_LSB        0
`define CBID_CAT_MSB          7
`define CBID_CAT_LSB          6
`define CBID_PART_MSB         5
`define CBID_PART_LSB         0

`define CBID_LEN_MSB          4
`define CBID_LEN_LSB          0
`define CBID_LEN_RESET        5'h08

`endif

// File: hdl/cbid_pkg.sv
/*
  Types shared by the identification register bank and its block-read sequencer.
  Assumes the defines header supplies all numeric values.
*/
package cbid_pkg;

  typedef logic [7:0] cbid_byte_t;
  typedef logic [4:0] cbid_len_t;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_DATA
  } cbid_seq_state_t;

endpackage

// File: hdl/cbid_block_seq.sv
/*
  Block-read sequencer: sends the byte count, then that many consecutive register bytes.
  Assumes the serial engine pulses blkNext once per acknowledged byte and that
  register data for seqIndex is supplied combinationally on the same clock.
*/
`timescale 1ns/1ns
`include "cbid_defines.svh"

module cbid_block_seq (
  // Clock, reset, enable.
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic               ce,
  // Block-read requests.
  input  wire logic               blkStart,
  input  wire logic [7:0]         blkIndex,
  input  wire logic               blkNext,
  input  wire logic               blkAbort,
  input  wire cbid_pkg::cbid_len_t readLength,
  // Register data lookup.
  output logic      [7:0]         seqIndex,
  input  wire cbid_pkg::cbid_byte_t seqRdData,
  // Byte stream out.
  output cbid_pkg::cbid_byte_t    blkData,
  output logic                    blkDataValid,
  output logic                    blkLast,
  output logic                    blkBusy
);

  cbid_pkg::cbid_seq_state_t state_r;
  cbid_pkg::cbid_len_t       remain_r;
  logic [7:0]                index_r;

  assign seqIndex = index_r;
  assign blkBusy  = (state_r == cbid_pkg::SEQ_DATA);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r      <= cbid_pkg::SEQ_IDLE;
      remain_r     <= 5'h00;
      index_r      <= 8'h00;
      blkData      <= 8'h00;
      blkDataValid <= 1'b0;
      blkLast      <= 1'b0;
    end else if (ce) begin
      blkDataValid <= 1'b0;
      case (state_r)
        cbid_pkg::SEQ_IDLE: begin
          if (blkStart) begin
            // The count goes out first, taken from the length register. [R5]
            blkData      <= {3'h0, readLength};
            blkDataValid <= 1'b1;
            blkLast      <= (readLength == 5'h00);
            remain_r     <= readLength;
            index_r      <= blkIndex;
            state_r      <= (readLength == 5'h00) ? cbid_pkg::SEQ_IDLE : cbid_pkg::SEQ_DATA;
          end
        end
        cbid_pkg::SEQ_DATA: begin
          if (blkAbort) begin
            state_r <= cbid_pkg::SEQ_IDLE;
          end else if (blkNext) begin
            // Consecutive bytes until the count is spent. [R5]
            blkData      <= seqRdData;
            blkDataValid <= 1'b1;
            blkLast      <= (remain_r == 5'h01);
            remain_r     <= remain_r - 5'h01;
            index_r      <= index_r + 8'h01;
            if (remain_r == 5'h01) begin
              state_r <= cbid_pkg::SEQ_IDLE;
            end
          end
        end
        default: begin
          state_r <= cbid_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  property p_count_first;
    @(posedge clk) disable iff (!reset_n)
    (ce && !blkBusy && blkStart) |=> (blkDataValid && blkData == {3'h0, $past(readLength)});
  endproperty
  a_count_first: assert property (p_count_first) else $error("Block read did not open with the count."); // [R5]

  property p_data_follows;
    @(posedge clk) disable iff (!reset_n)
    (ce && blkBusy && !blkAbort && blkNext) |=> (blkDataValid && blkData == $past(seqRdData));
  endproperty
  a_data_follows: assert property (p_data_follows) else $error("Block read byte did not follow request."); // [R5]

endmodule // cbid_block_seq

// File: verification/cbid_host_model.sv
/*
  Host model for block reads: acknowledges each byte but the last after a gap, or aborts.
  Assumes it drives on falling edges and the block samples on rising edges.
*/
`timescale 1ns/1ns

module cbid_host_model (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Behaviour chosen by the bench.
  input  wire logic [3:0] gapCycles,
  input  wire logic [4:0] abortAt,
  // Block stream.
  input  wire logic       blkBusy,
  input  wire logic       blkDataValid,
  input  wire logic       blkLast,
  output logic            blkNext,
  output logic            blkAbort
);
  logic [3:0] waitCnt;
  logic [4:0] gotCnt;
  logic       pending;
  logic       abortNow;

  assign abortNow = (abortAt != 5'h00) && (gotCnt == abortAt);

  // Idle clears the count, so a block that ends early cannot leak into the next.
  // Each branch gives every strobe one value, so no strobe is written twice per edge.
  always @(negedge clk) begin
    if (!reset_n || (!blkBusy && !blkDataValid)) begin
      blkNext  <= 1'b0;
      blkAbort <= 1'b0;
      pending  <= 1'b0;
      waitCnt  <= 4'h0;
      gotCnt   <= 5'h00;
    end else if (blkDataValid && !blkLast) begin
      blkNext  <= 1'b0;
      blkAbort <= 1'b0;
      pending  <= 1'b1;
      waitCnt  <= gapCycles;
      gotCnt   <= gotCnt + 5'h01;
    end else if (pending && waitCnt != 4'h0) begin
      blkNext  <= 1'b0;
      blkAbort <= 1'b0;
      waitCnt  <= waitCnt - 4'h1;
    end else if (pending) begin
      pending  <= 1'b0;
      blkAbort <= abortNow;
      blkNext  <= !abortNow;
    end else begin
      blkNext  <= 1'b0;
      blkAbort <= 1'b0;
    end
  end
endmodule // cbid_host_model

// File: verification/tb_clock_buffer_id_bytecount_regs.sv
/*
  Self-checking bench for the identification and block-length registers.
  Assumes one clock with ce held high except for one cycle in the freeze test; inputs change on falling edges.
*/
`timescale 1ns/1ns
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected %s: expected %h seen %h", nm, e, a); end end

module tb_clock_buffer_id_bytecount_regs;
  localparam logic [7:0] BYTE5 = {4'h3, 4'h5};
  localparam logic [7:0] BYTE6 = {2'h2, 6'h15};
  logic                 clk, reset_n, ce, accValid, accWrite, accRdValid;
  logic                 blkStart, blkNext, blkAbort, blkDataValid, blkLast, blkBusy;
  logic [7:0]           accIndex, blkIndex;
  cbid_pkg::cbid_byte_t accWrData, accRdData, blkData;
  cbid_pkg::cbid_len_t  readLength, curLen;
  logic [3:0]           gapCycles;
  logic [4:0]           abortAt;
  int                   fail_count, checks;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  cbid_regs #(.REVISION_CODE(4'h3), .MAKER_CODE(4'h5), .CATEGORY_CODE(2'h2), .PART_CODE(6'h15)) i_dut (
    .clk(clk), .reset_n(reset_n), .ce(ce), .accValid(accValid), .accWrite(accWrite), .accIndex(accIndex),
    .accWrData(accWrData), .accRdData(accRdData), .accRdValid(accRdValid), .blkStart(blkStart),
    .blkIndex(blkIndex), .blkNext(blkNext), .blkAbort(blkAbort), .blkData(blkData),
    .blkDataValid(blkDataValid), .blkLast(blkLast), .blkBusy(blkBusy), .readLength(readLength));

  cbid_host_model i_host (.clk(clk), .reset_n(reset_n), .gapCycles(gapCycles), .abortAt(abortAt),
    .blkBusy(blkBusy), .blkDataValid(blkDataValid), .blkLast(blkLast), .blkNext(blkNext), .blkAbort(blkAbort));

  function automatic cbid_pkg::cbid_byte_t expByte(input logic [7:0] idx);
    case (idx)
      8'h04: expByte = 8'hFF;
      8'h05: expByte = BYTE5;
      8'h06: expByte = BYTE6;
      8'h07: expByte = {3'h0, curLen};
      default: expByte = 8'h00;
    endcase
  endfunction

  task automatic access(input logic wr, input logic [7:0] idx, input cbid_pkg::cbid_byte_t d);
    @(negedge clk);
    accValid = 1'b1;
    accWrite = wr;
    accIndex = idx;
    accWrData = d;
    @(negedge clk);
    accValid = 1'b0;
    if (wr && idx == 8'h07) curLen = d[4:0];
  endtask

  task automatic rd(input logic [7:0] idx);
    access(1'b0, idx, 8'h00);
    `CHK("accRdValid", 1'b1, accRdValid)
    `CHK("accRdData", expByte(idx), accRdData)
  endtask

  task automatic t_reset_values;
    rd(8'h04);
    rd(8'h05);
    rd(8'h06);
    rd(8'h07);
    rd(8'h03);
    `CHK("readLength", 5'h08, readLength)
  endtask

  task automatic t_writes;
    access(1'b1, 8'h04, 8'h00);
    access(1'b1, 8'h05, 8'h00);
    access(1'b1, 8'h06, 8'h00);
    access(1'b1, 8'h07, 8'hFF);
    rd(8'h04);
    rd(8'h05);
    rd(8'h06);
    rd(8'h07);
    `CHK("readLength", 5'h1F, readLength)
  endtask

  task automatic t_block(input logic [7:0] n, input logic [3:0] gap, input logic [4:0] ab);
    logic [7:0] got;
    int         i;
    gapCycles = gap;
    abortAt = ab;
    got = 8'h00;
    @(negedge clk);
    blkStart = 1'b1;
    blkIndex = n;
    @(negedge clk);
    blkStart = 1'b0;
    for (i = 0; i < 150; i++) begin
      if (blkDataValid === 1'b1) begin
        `CHK("blkData", (got == 8'h00) ? {3'h0, curLen} : expByte(n + got - 8'h01), blkData)
        `CHK("blkLast", (got == {3'h0, curLen}), blkLast)
        got++;
      end
      @(negedge clk);
    end
    `CHK("byte total", (ab != 5'h00) ? {3'h0, ab} : {3'h0, curLen} + 8'h01, got)
    `CHK("blkBusy", 1'b0, blkBusy)
  endtask

  // A write while the enable is low must not land; then a reset while idle, after a length write.
  task automatic t_freeze_reset;
    @(negedge clk);
    ce = 1'b0;
    accValid = 1'b1;
    accWrite = 1'b1;
    accIndex = 8'h07;
    accWrData = 8'h11;
    @(negedge clk);
    accValid = 1'b0;
    ce = 1'b1;
    `CHK("readLength frozen", curLen, readLength)
    `CHK("accRdValid frozen", 1'b0, accRdValid)
    access(1'b1, 8'h07, 8'h15);
    reset_n = 1'b0;
    @(negedge clk);
    reset_n = 1'b1;
    curLen = 5'h08;
    `CHK("readLength reset", 5'h08, readLength)
    `CHK("blkBusy reset", 1'b0, blkBusy)
    rd(8'h07);
  endtask

  task test_done;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    test_done;
  end

  initial begin
    {reset_n, accValid, accWrite, blkStart} = 4'h0;
    {accIndex, accWrData, blkIndex} = 24'h000000;
    {gapCycles, abortAt} = 9'h000;
    curLen = 5'h08;
    ce = 1'b1;
    fail_count = 0;
    checks = 0;
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    t_reset_values;
    t_block(8'h04, 4'h0, 5'h00);
    t_writes;
    access(1'b1, 8'h07, 8'h03);
    t_block(8'h05, 4'h2, 5'h00);
    access(1'b1, 8'h07, 8'h02);
    t_block(8'hFF, 4'h1, 5'h00);
    access(1'b1, 8'h07, 8'h00);
    t_block(8'h05, 4'h0, 5'h00);
    access(1'b1, 8'h07, 8'h08);
    t_block(8'h04, 4'h0, 5'h02);
    t_freeze_reset;
    test_done;
  end
endmodule // tb_clock_buffer_id_bytecount_regs
